// [rtl/ppm_pkg.sv]
// Constants for the port pin function multiplexer
package ppm_pkg;
  localparam int NPORT = 5;
  localparam int PW = 8;
  // Port index
  localparam logic [2:0] PORT_KBD = 3'h0;
  localparam logic [2:0] PORT_ANALOG = 3'h1;
  localparam logic [2:0] PORT_HIGHDRIVE = 3'h2;
  localparam logic [2:0] PORT_SPECIAL = 3'h3;
  localparam logic [2:0] PORT_SERIAL = 3'h4;
  // Register map: port block at port*stride, register within block
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_DIR = 4'h4;
  localparam logic [3:0] REG_PULL = 4'h8;
  localparam logic [3:0] REG_FUNC = 4'hc;
  localparam logic [7:0] REG_STATUS = 8'h50;
  localparam int STAT_RST_PIN = 0;
  localparam int STAT_IRQ_PIN = 1;
  localparam int STAT_RST_DRIVE = 2;
  // Group enable bit in the function register of CAN, SPI and serial ports
  localparam int FN_GROUP_BIT = 0;
  // Reset values
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] RST_FUNC = 8'h00;
  // Bonded bits, pull-up capable bits and peripheral capable bits (index 4 first)
  localparam logic [NPORT-1:0][PW-1:0] IMPL_MASK = {8'h3f, 8'hff, 8'h7f, 8'hff, 8'hff};
  localparam logic [NPORT-1:0][PW-1:0] PULL_MASK = {8'h00, 8'hff, 8'h7f, 8'h00, 8'hff};
  localparam logic [NPORT-1:0][PW-1:0] FUNC_MASK = {8'h01, 8'hf1, 8'h01, 8'hff, 8'hff};
  // Cycles during which the reset pin is not sensed after the device lets go of it
  localparam logic [2:0] RST_BLANK_CYC = 3'h4;
  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage : ppm_pkg

// [rtl/ppm_sync.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ppm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } ppm_sync_t;

  ppm_sync_t s_q;
  ppm_sync_t s_d;

  always_comb begin
    s_d.first = async;
    s_d.second = s_q.first;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= {INIT, INIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign synced = s_q.second;
endmodule // ppm_sync
`default_nettype wire

// [rtl/ppm_port_mux.sv]
// Per-port choice between general-purpose and peripheral control
`timescale 1ns/100ps
`default_nettype none
module ppm_port_mux #(
  parameter int PW = 8,
  parameter logic [PW-1:0] IMPL = '1,
  parameter logic [PW-1:0] PULLCAP = '1
) (
  input wire logic [PW-1:0] data,
  input wire logic [PW-1:0] dir,
  input wire logic [PW-1:0] pull,
  input wire logic [PW-1:0] fnEn,
  input wire logic [PW-1:0] perOut,
  input wire logic [PW-1:0] perOe,
  output logic [PW-1:0] pinOut,
  output logic [PW-1:0] pinOe,
  output logic [PW-1:0] pullEn
);
  logic [PW-1:0] oe;

  always_comb begin
    oe = ((fnEn & perOe) | (~fnEn & dir)) & IMPL;
    pinOe = oe;
    pinOut = ((fnEn & perOut) | (~fnEn & data)) & IMPL;
    pullEn = pull & ~oe & PULLCAP & IMPL;
  end
endmodule // ppm_port_mux
`default_nettype wire

// [rtl/ppm_pin_mux.sv]
// Port pin function multiplexer with pull-ups, reset pin and interrupt pin
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module ppm_pin_mux (
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Port pins, index 0 keyboard .. 4 serial
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pinIn,
  output logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pinOut,
  output logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pinOe,
  output logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pullEn,
  // Peripheral side
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] perOut,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] perOe,
  output logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] perIn,
  output logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] perSel,
  // Reset and interrupt pins
  input wire logic intRstReq,
  input wire logic rstPinIn,
  output logic rstPinOut,
  output logic rstPinOe,
  output logic chipRstN,
  input wire logic irqPinIn,
  output logic irqPullEn,
  output logic irqLevel
);
  typedef logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] ppm_bank_t;

  typedef struct packed {
    ppm_bank_t data;
    ppm_bank_t dir;
    ppm_bank_t pull;
    ppm_bank_t fn;
    ppm_bank_t pinOut;
    ppm_bank_t pinOe;
    ppm_bank_t pullEn;
    ppm_bank_t perSel;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdata;
    logic rstOe;
    logic chipRstN;
    logic [2:0] blank;
    logic irqLevel;
  } ppm_state_t;

  ppm_state_t s_q;
  ppm_state_t s_d;
  ppm_bank_t pinSync;
  ppm_bank_t muxOut;
  ppm_bank_t muxOe;
  ppm_bank_t muxPull;
  logic [1:0] ctlSync;
  logic extRst;
  ppm_bank_t fnEnAll;

  // Bit enables from the function register; grouped pins share one enable bit, special port bits 7:4 have their own
  function automatic logic [7:0] fn_bits(input logic [2:0] port, input logic [7:0] r);
    logic g;
    g = r[ppm_pkg::FN_GROUP_BIT];
    case (port)
      ppm_pkg::PORT_HIGHDRIVE: begin
        fn_bits = {6'h00, {2{g}}};
      end
      ppm_pkg::PORT_SPECIAL: begin
        fn_bits = {r[7:4], {4{g}}};
      end
      ppm_pkg::PORT_SERIAL: begin
        fn_bits = {6'h00, {2{g}}};
      end
      default: begin
        fn_bits = r;
      end
    endcase
  endfunction

  // Data register reads the latch for outputs and the pin for inputs
  function automatic logic [7:0] data_view(input logic [7:0] d, input logic [7:0] oe, input logic [7:0] pin);
    logic [7:0] fromLatch;
    logic [7:0] fromPin;
    fromLatch = d & oe;
    fromPin = pin & ~oe;
    data_view = fromLatch | fromPin;
  endfunction

  // Port and register fields of a bus address
  function automatic logic [2:0] addr_port(input logic [7:0] a);
    addr_port = a[6:4];
  endfunction

  function automatic logic [3:0] addr_reg(input logic [7:0] a);
    addr_reg = a[3:0];
  endfunction

  // Inside the port area and word aligned; no aliases above it
  function automatic logic reg_hit(input logic [7:0] a);
    logic inArea;
    inArea = a < (ppm_pkg::PORT_STRIDE * 8'(ppm_pkg::NPORT));
    reg_hit = inArea && (a[1:0] == 2'b00);
  endfunction

  // Same byte in every port
  function automatic ppm_bank_t fill_bank(input logic [7:0] v);
    fill_bank = {ppm_pkg::NPORT{v}};
  endfunction

  // Bits owned by a peripheral, shared by the pin muxes and the select outputs
  always_comb begin
    for (int p = 0; p < ppm_pkg::NPORT; p++) begin
      fnEnAll[p] = fn_bits(3'(p), s_q.fn[p]) & ppm_pkg::IMPL_MASK[p];
    end
  end

  ppm_sync #(
    .WIDTH(ppm_pkg::NPORT * ppm_pkg::PW),
    .INIT('0)
  ) u_port_sync (
    .clk(clk),
    .nrst(nrst),
    .async(pinIn),
    .synced(pinSync)
  );

  ppm_sync #(
    .WIDTH(2),
    .INIT(2'b11)
  ) u_ctl_sync (
    .clk(clk),
    .nrst(nrst),
    .async({irqPinIn, rstPinIn}),
    .synced(ctlSync)
  );

  for (genvar p = 0; p < ppm_pkg::NPORT; p++) begin : g_port
    ppm_port_mux #(
      .PW(ppm_pkg::PW),
      .IMPL(ppm_pkg::IMPL_MASK[p]),
      .PULLCAP(ppm_pkg::PULL_MASK[p])
    ) u_mux (
      .data(s_q.data[p]),
      .dir(s_q.dir[p]),
      .pull(s_q.pull[p]),
      .fnEn(fnEnAll[p]),
      .perOut(perOut[p]),
      .perOe(perOe[p]),
      .pinOut(muxOut[p]),
      .pinOe(muxOe[p]),
      .pullEn(muxPull[p])
    );
  end

  // Pin low while the device is not driving it and not in the release window
  assign extRst = !ctlSync[0] && !s_q.rstOe && (s_q.blank == 3'h0);

  always_comb begin
    logic rd;
    logic wr;
    logic [2:0] port;
    logic [3:0] reg_;
    logic [7:0] wd;
    logic take;
    take = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    port = 3'h0;
    reg_ = 4'h0;
    wd = 8'h00;
    s_d = s_q;

    // Write data phase
    if (s_q.wrPend && reg_hit(s_q.wrAddr)) begin
      port = addr_port(s_q.wrAddr);
      reg_ = addr_reg(s_q.wrAddr);
      wd = hwdata[7:0];
      case (reg_)
        ppm_pkg::REG_DATA: begin
          s_d.data[port] = wd & ppm_pkg::IMPL_MASK[port];
        end
        ppm_pkg::REG_DIR: begin
          s_d.dir[port] = wd & ppm_pkg::IMPL_MASK[port];
        end
        ppm_pkg::REG_PULL: begin
          s_d.pull[port] = wd & ppm_pkg::IMPL_MASK[port] & ppm_pkg::PULL_MASK[port];
        end
        ppm_pkg::REG_FUNC: begin
          s_d.fn[port] = wd & ppm_pkg::FUNC_MASK[port];
        end
        default: begin
          s_d.fn[port] = s_q.fn[port];
        end
      endcase
    end

    // Address phase: single NONSEQ transfers, never a wait state
    take = hsel && hready && (htrans == ppm_pkg::HTRANS_NONSEQ);
    wr = take && hwrite;
    rd = take && !hwrite;
    s_d.wrPend = wr;
    s_d.wrAddr = wr ? haddr[7:0] : 8'h00;
    s_d.rdata = 32'h0000_0000;
    if (rd && reg_hit(haddr[7:0])) begin
      port = addr_port(haddr[7:0]);
      reg_ = addr_reg(haddr[7:0]);
      case (reg_)
        ppm_pkg::REG_DATA: begin
          s_d.rdata[7:0] = data_view(s_d.data[port], s_q.pinOe[port], pinSync[port])
                           & ppm_pkg::IMPL_MASK[port];
        end
        ppm_pkg::REG_DIR: begin
          s_d.rdata[7:0] = s_d.dir[port];
        end
        ppm_pkg::REG_PULL: begin
          s_d.rdata[7:0] = s_d.pull[port];
        end
        ppm_pkg::REG_FUNC: begin
          s_d.rdata[7:0] = s_d.fn[port];
        end
        default: begin
          s_d.rdata[7:0] = 8'h00;
        end
      endcase
    end else if (rd && (haddr[7:0] == ppm_pkg::REG_STATUS)) begin
      s_d.rdata[ppm_pkg::STAT_RST_PIN] = ctlSync[0];
      s_d.rdata[ppm_pkg::STAT_IRQ_PIN] = ctlSync[1];
      s_d.rdata[ppm_pkg::STAT_RST_DRIVE] = s_q.rstOe;
    end

    // Reset pin: drive low for internal sources, blank sensing while it rises
    s_d.rstOe = intRstReq;
    if (s_q.rstOe) begin
      s_d.blank = ppm_pkg::RST_BLANK_CYC;
    end else if (s_q.blank != 3'h0) begin
      s_d.blank = s_q.blank - 3'h1;
    end else begin
      s_d.blank = 3'h0;
    end
    s_d.chipRstN = !(extRst || intRstReq);
    s_d.irqLevel = ctlSync[1];

    // External reset returns the control registers to their startup values
    if (extRst) begin
      s_d.data = fill_bank(ppm_pkg::RST_DATA);
      s_d.dir = fill_bank(ppm_pkg::RST_DIR);
      s_d.pull = fill_bank(ppm_pkg::RST_PULL);
      s_d.fn = fill_bank(ppm_pkg::RST_FUNC);
      s_d.wrPend = 1'b0;
    end

    // Registered pin and peripheral controls
    s_d.pinOut = muxOut;
    s_d.pinOe = muxOe;
    s_d.pullEn = muxPull;
    s_d.perSel = fnEnAll;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.chipRstN <= 1'b0;
      s_q.irqLevel <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1 | s_q.wrPend;
  assign hresp = 1'b0 & s_q.wrPend;
  assign hrdata = s_q.rdata;
  assign pinOut = s_q.pinOut;
  assign pinOe = s_q.pinOe;
  assign pullEn = s_q.pullEn;
  assign perIn = pinSync;
  assign perSel = s_q.perSel;
  assign rstPinOut = 1'b0 & s_q.rstOe;
  assign rstPinOe = s_q.rstOe;
  assign chipRstN = s_q.chipRstN;
  assign irqPullEn = s_q.chipRstN | 1'b1;
  assign irqLevel = s_q.irqLevel;
endmodule // ppm_pin_mux
`default_nettype wire

// [test/ppm_pin_mux_props.sv]
// Port-level checker for the pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module ppm_pin_mux_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pinOut,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pinOe,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pullEn,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] perOut,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] perOe,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] perSel,
  input wire logic intRstReq,
  input wire logic rstPinIn,
  input wire logic rstPinOe,
  input wire logic chipRstN,
  input wire logic irqPinIn,
  input wire logic irqPullEn,
  input wire logic irqLevel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rstLow;
    (!rstPinIn && !rstPinOe) [*8];
  endsequence
  sequence s_irqSteady;
    $stable(irqPinIn) [*4];
  endsequence
  a_pull_off_out: assert property ((pullEn & pinOe) == '0)
    else $error("pull-up on a driven bit");
  a_pull_cap_only: assert property ((pullEn & ~ppm_pkg::PULL_MASK) == '0)
    else $error("pull-up on a port without pull-ups");
  a_rst_drive_low: assert property (intRstReq |=> rstPinOe && !chipRstN)
    else $error("reset pin not driven on internal reset");
  a_rst_pin_in: assert property (s_rstLow |-> !chipRstN)
    else $error("low reset pin did not reset the chip");
  a_irq_pull_on: assert property (irqPullEn)
    else $error("interrupt pin pull-up off");
  a_irq_level: assert property (s_irqSteady |-> irqLevel == irqPinIn)
    else $error("interrupt level does not follow the pin");
  a_take_oe: assert property ((pinOe & perSel) == ($past(perOe) & perSel))
    else $error("peripheral does not own pin enable");
  a_take_out: assert property ((pinOut & perSel) == ($past(perOut) & perSel))
    else $error("peripheral does not own pin value");
endmodule // ppm_pin_mux_props
bind ppm_pin_mux ppm_pin_mux_props u_props (.clk(clk), .nrst(nrst), .pinOut(pinOut), .pinOe(pinOe),
  .pullEn(pullEn), .perOut(perOut), .perOe(perOe), .perSel(perSel), .intRstReq(intRstReq),
  .rstPinIn(rstPinIn), .rstPinOe(rstPinOe), .chipRstN(chipRstN), .irqPinIn(irqPinIn),
  .irqPullEn(irqPullEn), .irqLevel(irqLevel));
`default_nettype wire

// [test/ppm_far_side.sv]
// Board and peripheral model on the far side of the pins
`timescale 1ns/100ps
`default_nettype none
module ppm_far_side (
  input wire logic clk,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pinOut,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pinOe,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pullEn,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] extDrv,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] extLvl,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] cmdOut,
  input wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] cmdOe,
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  input wire logic irqPullEn,
  input wire logic extRstLow,
  input wire logic extIrqLow,
  output logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pinIn,
  output logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] perOut,
  output logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] perOe,
  output logic rstPinIn,
  output logic irqPinIn
);
  logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] flt = '0;
  // Undriven, unpulled pins wander
  always @(posedge clk) flt <= ~flt;
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrv & extLvl) | (~pinOe & ~extDrv & (pullEn | flt));
  assign perOut = cmdOut;
  // Keyboard and converter inputs never drive
  assign perOe = cmdOe & {{3{8'hff}}, 16'h0000};
  assign rstPinIn = rstPinOe ? rstPinOut : !extRstLow;
  assign irqPinIn = extIrqLow ? 1'b0 : (irqPullEn ? 1'b1 : flt[0][0]);
endmodule // ppm_far_side
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [4:0][7:0] FN_EXP = {8'h03, 8'hff, 8'h03, 8'hff, 8'hff};
  logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, intRstReq, rstPinIn, rstPinOut, rstPinOe;
  logic chipRstN, irqPinIn, irqPullEn, irqLevel, extRstLow, extIrqLow;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0][7:0] pinIn, pinOut, pinOe, pullEn, perOut, perOe, perIn, perSel, extDrv, extLvl, cmdOut, cmdOe;
  int nFail = 0, checked = 0, cyc = 0;
  assign hready = hreadyout;
  ppm_pin_mux DUT (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullEn(pullEn), .perOut(perOut), .perOe(perOe),
    .perIn(perIn), .perSel(perSel), .intRstReq(intRstReq), .rstPinIn(rstPinIn), .rstPinOut(rstPinOut),
    .rstPinOe(rstPinOe), .chipRstN(chipRstN), .irqPinIn(irqPinIn), .irqPullEn(irqPullEn), .irqLevel(irqLevel));
  ppm_far_side u_far (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullEn(pullEn), .extDrv(extDrv),
    .extLvl(extLvl), .cmdOut(cmdOut), .cmdOe(cmdOe), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .irqPullEn(irqPullEn), .extRstLow(extRstLow), .extIrqLow(extIrqLow), .pinIn(pinIn), .perOut(perOut),
    .perOe(perOe), .rstPinIn(rstPinIn), .irqPinIn(irqPinIn));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= ppm_pkg::HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, v);
  endtask
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      nFail++;
      close_out();
    end
  end
  initial begin
    nrst = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = '0;
    intRstReq = 1'b0; extRstLow = 1'b0; extIrqLow = 1'b0; cmdOut = '0; cmdOe = '0;
    extDrv = '1;
    extLvl = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    xfer(8'h04, 1'b0, 32'h0, v);
    chk("dir0 reset", v, 32'h0);
    wr(8'h08, 32'h5a);
    wr(8'h04, 32'h0f);
    settle();
    chk("pull0", pullEn[0], 8'h50);
    wr(8'h84, 32'hff);
    xfer(8'h04, 1'b0, 32'h0, v);
    chk("dir0 alias", v, 32'h0f);
    wr(8'h18, 32'hff);
    settle();
    chk("pull1", pullEn[1], 8'h00);
    for (int p = 0; p < 5; p++) begin
      wr(8'(p * 16 + 12), 32'hff);
      settle();
      chk("func sel", perSel[p], FN_EXP[p]);
    end
    @(posedge clk);
    cmdOut[3] <= 8'h05;
    cmdOe[3] <= 8'h0f;
    cmdOe[2] <= 8'hff;
    cmdOut[2] <= 8'hff;
    settle();
    chk("spi oe", pinOe[3], 8'h0f);
    chk("spi out", pinOut[3], 8'h05);
    chk("can oe", pinOe[2], 8'h03);
    wr(8'h3c, 32'h20);
    settle();
    chk("timer sel", perSel[3], 8'h20);
    @(posedge clk) extLvl[1] <= 8'ha5;
    settle();
    chk("adc in", perIn[1], 8'ha5);
    xfer(8'h10, 1'b0, 32'h0, v);
    chk("adc data", v, 32'ha5);
    xfer(8'h60, 1'b0, 32'h0, v);
    chk("unmapped", v, 32'h0);
    @(posedge clk) extIrqLow <= 1'b1;
    settle();
    chk("irq low", irqLevel, 1'b0);
    xfer(8'h50, 1'b0, 32'h0, v);
    chk("status", v, 32'h1);
    chk("bus resp", hresp, 1'b0);
    @(posedge clk) extIrqLow <= 1'b0;
    settle();
    chk("irq pulled", irqLevel, 1'b1);
    @(posedge clk) intRstReq <= 1'b1;
    @(posedge clk) intRstReq <= 1'b0;
    @(negedge clk);
    chk("rst drive", {rstPinOe, rstPinOut, chipRstN}, 3'b100);
    repeat (10) @(posedge clk);
    extRstLow <= 1'b1;
    repeat (10) @(negedge clk);
    chk("ext reset", chipRstN, 1'b0);
    @(posedge clk) extRstLow <= 1'b0;
    repeat (10) @(posedge clk);
    xfer(8'h0c, 1'b0, 32'h0, v);
    chk("func0 cleared", v, 32'h0);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
